/* bench/ces_comp_model.sv */
// Purpose: behavioural comparator output seen by the event sense block
// Assumes: the bench sets the wanted level and a settle delay in ns
// Notes:   clean transitions only; a real comparator may chatter near threshold
`timescale 1ns/1ns
module ces_comp_model (
  input  wire logic       want,     // requested output level
  input  wire logic [4:0] dly_ns,   // settle delay, prompt or slow
  output logic            comp_out  // comparator output, async to hclk
);
  // output follows the request after a delay off the clock grid
  always @(want) begin
    comp_out <= #(dly_ns) want;
  end

  // comparator starts low
  initial comp_out = 1'b0;
endmodule : ces_comp_model

/* bench/comparator_event_sense_tb_top.sv */
// Purpose: self-checking bench for the comparator event sense block
// Assumes: zero-wait AHB-Lite slave, comparator model on comp_out
// Notes:   fixed settle of 10 cycles covers the 4-edge sense path
`timescale 1ns/1ns
module comparator_event_sense_tb_top;
  import ces_pkg::*;
  typedef struct {
    logic [11:0] ctrl; // control word
    logic        c0;   // comparator level before
    logic        c1;   // comparator level after
    int          cnt;  // trigger pulses expected
    logic        trg;  // trig_out level at the end
    logic [1:0]  st;   // status {trigger, interrupt}
  } ces_row_type;

  logic        hclk = 1'b0;      // system clock
  logic        hresetn = 1'b0;   // reset, active low
  logic        hsel = 1'b0;      // slave select
  logic [11:0] haddr = 12'h000;  // byte address
  logic [1:0]  htrans = 2'h0;    // transfer type
  logic        hwrite = 1'b0;    // write strobe
  logic [2:0]  hsize = 3'h2;     // word transfers
  logic [31:0] hwdata = 32'h0000_0000; // write data
  logic [31:0] hrdata;           // read data
  logic [31:0] rd;               // last read word
  logic        hreadyout;        // slave ready
  logic        hresp;            // slave response
  logic        want = 1'b0;      // comparator level request
  logic [4:0]  dly = 5'h03;      // comparator settle delay
  logic        comp_out;         // comparator output
  logic        trig_out;         // converter trigger
  logic        irq;              // interrupt line
  logic        trg_prev = 1'b0;  // trig_out one cycle ago
  int          miscompares = 0;  // mismatches seen
  int          checks_done = 0;  // comparisons made
  int          rises = 0;        // trig_out rising edges
  int          base;             // rises at phase start

  // ordinary cases: edge and level modes on both paths
  ces_row_type rows [9] = '{
    '{12'h844, 1'b0, 1'b1, 1, 1'b0, 2'h2}, '{12'h828, 1'b0, 1'b1, 0, 1'b0, 2'h1},
    '{12'h86c, 1'b1, 1'b0, 1, 1'b0, 2'h3}, '{12'h824, 1'b1, 1'b0, 1, 1'b0, 2'h3},
    '{12'h890, 1'b0, 1'b1, 1, 1'b1, 2'h3}, '{12'h800, 1'b1, 1'b0, 1, 1'b1, 2'h3},
    '{12'h852, 1'b1, 1'b0, 1, 1'b0, 2'h3}, '{12'h044, 1'b0, 1'b1, 0, 1'b0, 2'h2},
    '{12'h80a, 1'b0, 1'b1, 1, 1'b1, 2'h2}};

  // 20 MHz clock
  always #25 hclk = ~hclk;

  // count trigger pulses; level mode shows as one rise
  always @(posedge hclk) begin
    trg_prev <= trig_out;
    if (trig_out === 1'b1 && trg_prev === 1'b0) begin
      rises <= rises + 1;
    end
  end

  ces_top ces_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .comp_out(comp_out), .trig_out(trig_out), .irq(irq));

  ces_comp_model ces_comp_model_i (.want(want), .dly_ns(dly), .comp_out(comp_out));

  // counts, verdict, end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // one comparison, four-state exact
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // single AHB-Lite word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      miscompares++;
      print_verdict();
    end
  endtask : bus

  // whole-run limit against a hang
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge hclk);
    check("ready in reset", hreadyout, 32'h0000_0001);
    check("trigger in reset", trig_out, 32'h0000_0000);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, CES_CTRL_OFS, 32'h0000_0000);
    check("control reset", rd, CES_CTRL_RESET);
    check("response okay", hresp, 32'h0000_0000);
    bus(1'b1, CES_CTRL_OFS, 32'hffff_ffff);
    bus(1'b0, CES_CTRL_OFS, 32'h0000_0000);
    check("control mask", rd, CES_CTRL_MASK);
    bus(1'b0, 12'h100, 32'h0000_0000);
    check("unmapped read", rd, 32'h0000_0000);
    $display("test registers done");
    foreach (rows[i]) begin
      dly <= (i % 2 == 0) ? 5'h03 : 5'h11;
      want <= rows[i].c0;
      bus(1'b1, CES_CTRL_OFS, 32'(rows[i].ctrl));
      repeat (10) @(posedge hclk);
      bus(1'b1, CES_CLR_OFS, 32'h0000_0003);
      repeat (2) @(posedge hclk);
      base = rises;
      want <= rows[i].c1;
      repeat (10) @(posedge hclk);
      check("trigger pulses", rises - base, rows[i].cnt);
      check("trigger level", trig_out, rows[i].trg);
      bus(1'b0, CES_STAT_OFS, 32'h0000_0000);
      check("status", rd, 32'(rows[i].st));
      bus(1'b0, CES_OUT_OFS, 32'h0000_0000);
      check("live level", rd, 32'(rows[i].c1 ^ rows[i].ctrl[1]));
      $display("test row %0d done", i);
    end
    // interrupt: masked, raised, cleared
    bus(1'b1, CES_CTRL_OFS, 32'h0000_0844);
    want <= 1'b0;
    repeat (10) @(posedge hclk);
    bus(1'b1, CES_CLR_OFS, 32'h0000_0003);
    bus(1'b1, CES_IEN_OFS, 32'h0000_0001);
    want <= 1'b1;
    repeat (10) @(posedge hclk);
    check("irq masked", irq, 32'h0000_0000);
    bus(1'b1, CES_IEN_OFS, 32'h0000_0003);
    repeat (2) @(posedge hclk);
    check("irq raised", irq, 32'h0000_0001);
    bus(1'b1, CES_CLR_OFS, 32'h0000_0002);
    repeat (2) @(posedge hclk);
    check("irq cleared", irq, 32'h0000_0000);
    $display("test interrupt done");
    // reset in mid run: irq, trigger and read data drop, registers return to reset values
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check("irq mid reset", irq, 32'h0000_0000);
    check("trigger mid reset", trig_out, 32'h0000_0000);
    check("read data mid reset", hrdata, 32'h0000_0000);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, CES_CTRL_OFS, 32'h0000_0000);
    check("control after reset", rd, CES_CTRL_RESET);
    bus(1'b0, CES_IEN_OFS, 32'h0000_0000);
    check("enable after reset", rd, 32'h0000_0000);
    $display("test reset done");
    print_verdict();
  end
endmodule : comparator_event_sense_tb_top

/* core/ces_edge_det.sv */
// Purpose: synchronise and condition the comparator output, find its edges
// Assumes: comp_out is asynchronous to hclk
// Notes:   two-stage synchroniser; edges compare to the previous cycle
`timescale 1ns/1ns
module ces_edge_det
  import ces_pkg::*;
(
  input  wire logic  hclk,     // system clock
  input  wire logic  hresetn,  // async reset, active low
  input  wire logic  comp_out, // raw comparator output
  input  wire logic  invert,   // output invert control
  ces_sense_if.src   sense     // conditioned level and edges
);

  logic sync1_q;  // first synchroniser stage, read only by sync2
  logic sync2_q;  // second synchroniser stage
  logic cond_q;   // conditioned level
  logic prev_q;   // conditioned level one cycle ago

  // synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= comp_out;
      sync2_q <= sync1_q;
    end
  end

  // inversion before any sensing uses the level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      cond_q <= sync2_q ^ invert;
      prev_q <= cond_q;
    end
  end

  assign sense.level = cond_q;
  assign sense.rise  = cond_q & ~prev_q;
  assign sense.fall  = ~cond_q & prev_q;

  // an invert change alone also shows as an edge; that matches the hardware
  // seeing a changed output after conditioning
  edge_pulse_a : assert property (@(posedge hclk) disable iff (!hresetn)
    sense.rise |-> !sense.fall && $past(cond_q) == 1'b0)
    else $error("rise pulse without low to high change");

endmodule : ces_edge_det

/* core/ces_pkg.sv */
// Purpose: shared constants and types for the comparator event sense block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   control layout follows the comparator control word
package ces_pkg;

  // register byte offsets
  localparam logic [11:0] CES_CTRL_OFS    = 12'h0024; // comparator control
  localparam logic [11:0] CES_STAT_OFS    = 12'h0000; // sticky event status, read only
  localparam logic [11:0] CES_CLR_OFS     = 12'h0004; // write one to clear status
  localparam logic [11:0] CES_IEN_OFS     = 12'h0008; // interrupt enable
  localparam logic [11:0] CES_OUT_OFS     = 12'h000c; // live conditioned output, read only

  // control field positions
  localparam int CES_INV_BIT    = 1;  // output invert
  localparam int CES_INTERRUPT_SENSE_SELECT_LSB   = 2;  // interrupt sense select, 2 bits
  localparam int CES_ISLV_BIT   = 4;  // interrupt level value
  localparam int CES_TRIGGER_SENSE_SELECT_LSB   = 5;  // trigger sense select, 2 bits
  localparam int CES_TSLV_BIT   = 7;  // trigger level value
  localparam int CES_TRIGGER_OUTPUT_ENABLE_BIT   = 11; // trigger output enable

  // writable bits of control, everything else reads zero
  localparam logic [31:0] CES_CTRL_MASK  = 32'h0000_08fe;
  localparam logic [31:0] CES_CTRL_RESET = 32'h0000_0000;

  // status bit positions
  localparam int CES_ST_IRQ     = 0;  // interrupt sense event seen
  localparam int CES_ST_TRG     = 1;  // converter trigger event seen
  localparam int CES_NUM_EVT    = 2;  // number of status bits

  // sense selection codes
  typedef enum logic [1:0] {
    CES_SENSE_LEVEL   = 2'h0,
    CES_SENSE_FALL    = 2'h1,
    CES_SENSE_RISE    = 2'h2,
    CES_SENSE_EITHER  = 2'h3
  } ces_sense_type;

endpackage : ces_pkg

/* core/ces_sense_if.sv */
// Purpose: carries the conditioned comparator level and its edges to sense units
// Assumes: all signals on hclk
// Notes:   one producer (edge detector), two consumers (interrupt and trigger sense selectors)
`timescale 1ns/1ns
interface ces_sense_if;
  logic level;    // conditioned output, current cycle
  logic rise;     // one-cycle rising edge pulse
  logic fall;     // one-cycle falling edge pulse

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : ces_sense_if

/* core/ces_sense_sel.sv */
// Purpose: one sense selector: level, falling, rising or either edge
// Assumes: edges are single-cycle pulses from ces_edge_det
// Notes:   combinational; caller registers the result
`timescale 1ns/1ns
module ces_sense_sel
  import ces_pkg::*;
(
  ces_sense_if.dst        sense,     // conditioned level and edges
  input  wire logic [1:0] sel,       // sense select code
  input  wire logic       level_val, // active level in level mode
  output logic            hit        // event this cycle
);

  // pick the detection form from the select code
  always_comb begin
    unique case (ces_sense_type'(sel))
      CES_SENSE_LEVEL:  hit = (sense.level == level_val);
      CES_SENSE_FALL:   hit = sense.fall;
      CES_SENSE_RISE:   hit = sense.rise;
      CES_SENSE_EITHER: hit = sense.rise | sense.fall;
    endcase
  end

endmodule : ces_sense_sel

/* core/ces_top.sv */
// Purpose: comparator event sense: interrupt and converter trigger from one output
// Assumes: AHB-Lite slave, single word transfers, hclk 20 MHz
// Notes:   zero-wait-state slave; all outputs registered
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module ces_top
  import ces_pkg::*;
(
  input  wire logic        hclk,       // system clock
  input  wire logic        hresetn,    // async reset, active low
  input  wire logic        hsel,       // slave select
  input  wire logic [11:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write when high
  input  wire logic [2:0]  hsize,      // transfer size
  input  wire logic        hready,     // bus ready in
  input  wire logic [31:0] hwdata,     // write data
  output logic      [31:0] hrdata,     // read data
  output logic             hreadyout,  // always ready
  output logic             hresp,      // always okay
  input  wire logic        comp_out,   // raw comparator output
  output logic             trig_out,   // converter trigger event
  output logic             irq         // level interrupt
);

  ces_sense_if sense ();

  logic [31:0]            ctrl_q;     // comparator control
  logic [CES_NUM_EVT-1:0] stat_q;     // sticky event status
  logic [CES_NUM_EVT-1:0] ien_q;      // interrupt enable
  logic                   ph_wr_q;    // pending write data phase
  logic [11:0]            ph_addr_q;  // latched write address
  logic                   irq_hit;    // interrupt sense event
  logic                   trg_hit;    // trigger sense event
  logic [31:0]            rdata_d;    // read mux
  logic                   addr_ok;    // valid address phase
  logic [CES_NUM_EVT-1:0] clr_d;      // clear strobes this cycle
  logic [CES_NUM_EVT-1:0] set_d;      // set strobes this cycle

  // edge detection and conditioning
  ces_edge_det u_edge (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .comp_out (comp_out),
    .invert   (ctrl_q[CES_INV_BIT]),
    .sense    (sense)
  );

  // interrupt path sensing
  ces_sense_sel u_irq_sel (
    .sense     (sense),
    .sel       (ctrl_q[CES_INTERRUPT_SENSE_SELECT_LSB +: 2]),
    .level_val (ctrl_q[CES_ISLV_BIT]),
    .hit       (irq_hit)
  );

  // converter trigger path sensing
  ces_sense_sel u_trg_sel (
    .sense     (sense),
    .sel       (ctrl_q[CES_TRIGGER_SENSE_SELECT_LSB +: 2]),
    .level_val (ctrl_q[CES_TSLV_BIT]),
    .hit       (trg_hit)
  );

  assign addr_ok = hsel & hready & htrans[1];

  // address phase capture; writes complete in the following cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_q   <= 1'b0;
      ph_addr_q <= 12'h000;
    end else begin
      ph_wr_q   <= addr_ok & hwrite;
      ph_addr_q <= haddr;
    end
  end

  // control register write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CES_CTRL_RESET;
    end else if (ph_wr_q && ph_addr_q == CES_CTRL_OFS) begin
      ctrl_q <= hwdata & CES_CTRL_MASK;
    end
  end

  // interrupt enable write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_q <= '0;
    end else if (ph_wr_q && ph_addr_q == CES_IEN_OFS) begin
      ien_q <= hwdata[CES_NUM_EVT-1:0];
    end
  end

  // sticky status; set wins over a same-cycle clear
  always_comb begin
    set_d = '0;
    set_d[CES_ST_IRQ] = irq_hit;
    set_d[CES_ST_TRG] = trg_hit;
    clr_d = (ph_wr_q && ph_addr_q == CES_CLR_OFS) ? hwdata[CES_NUM_EVT-1:0] : '0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr_d) | set_d;
    end
  end

  // interrupt output, high while an enabled status bit is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((stat_q & ~clr_d) | set_d) & ien_q);
    end
  end

  // converter trigger, gated by the output enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_out <= 1'b0;
    end else begin
      trig_out <= trg_hit & ctrl_q[CES_TRIGGER_OUTPUT_ENABLE_BIT];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (haddr)
      CES_CTRL_OFS: rdata_d = ctrl_q;
      CES_STAT_OFS: rdata_d = {{(32-CES_NUM_EVT){1'b0}}, stat_q};
      CES_IEN_OFS:  rdata_d = {{(32-CES_NUM_EVT){1'b0}}, ien_q};
      CES_OUT_OFS:  rdata_d = {31'h0000_0000, sense.level};
      default:      rdata_d = 32'h0000_0000;
    endcase
  end

  // read data registered into the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rdata_d;
    end
  end

  // slave never stalls and never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // assertions; edge forms are checked against the detector pulses,
  // so a wrong select decode shows up even when the level is quiet

  // trigger path select code
  sequence s_trg_code(logic [1:0] code);
    ctrl_q[CES_TRIGGER_SENSE_SELECT_LSB +: 2] == code;
  endsequence

  // interrupt path select code
  sequence s_irq_code(logic [1:0] code);
    ctrl_q[CES_INTERRUPT_SENSE_SELECT_LSB +: 2] == code;
  endsequence

  // an enabled trigger event this cycle
  sequence s_trg_event;
    trg_hit && ctrl_q[CES_TRIGGER_OUTPUT_ENABLE_BIT];
  endsequence

  // a clear write in its data phase
  sequence s_clr_write;
    ph_wr_q && ph_addr_q == CES_CLR_OFS;
  endsequence

  // a read address phase that the slave takes
  sequence s_rd_addr;
    addr_ok && !hwrite;
  endsequence

  // enabled event reaches the converter next cycle
  trig_gate_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_trg_event |=> trig_out)
    else $error("enabled trigger event not forwarded");

  // disabled gate suppresses every event
  trig_block_a : assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_q[CES_TRIGGER_OUTPUT_ENABLE_BIT] |=> !trig_out)
    else $error("trigger forwarded while disabled");

  // no trigger without a sense event
  trig_only_a : assert property (@(posedge hclk) disable iff (!hresetn)
    !trg_hit |=> !trig_out)
    else $error("trigger without event");

  // trigger level form
  trg_level_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_trg_code(2'h0) |-> trg_hit == (sense.level == ctrl_q[CES_TSLV_BIT]))
    else $error("trigger level sense wrong");

  // trigger falling edge form
  trg_fall_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_trg_code(2'h1) |-> trg_hit == sense.fall)
    else $error("trigger fall sense wrong");

  // trigger rising edge form
  trg_rise_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_trg_code(2'h2) |-> trg_hit == sense.rise)
    else $error("trigger rise sense wrong");

  // trigger either edge form
  trg_either_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_trg_code(2'h3) |-> trg_hit == (sense.rise || sense.fall))
    else $error("trigger either sense wrong");

  // high level value: low output gives no event
  trg_lvlval_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_trg_code(2'h0) ##0 (ctrl_q[CES_TSLV_BIT] && !sense.level) |-> !trg_hit)
    else $error("trigger level value ignored");

  // high level value: high output gives an event
  trg_lvlhigh_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_trg_code(2'h0) ##0 (ctrl_q[CES_TSLV_BIT] && sense.level) |-> trg_hit)
    else $error("high level trigger missing");

  // interrupt level form
  irq_level_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_irq_code(2'h0) |-> irq_hit == (sense.level == ctrl_q[CES_ISLV_BIT]))
    else $error("interrupt level sense wrong");

  // interrupt falling edge form
  irq_fall_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_irq_code(2'h1) |-> irq_hit == sense.fall)
    else $error("interrupt fall sense wrong");

  // interrupt rising edge form
  irq_rise_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_irq_code(2'h2) |-> irq_hit == sense.rise)
    else $error("interrupt rise sense wrong");

  // interrupt either edge form
  either_edge_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_irq_code(2'h3) |-> irq_hit == (sense.rise || sense.fall))
    else $error("either edge missed");

  // low level value: low output raises it
  irq_lvlval_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_irq_code(2'h0) ##0 (!ctrl_q[CES_ISLV_BIT] && !sense.level) |-> irq_hit)
    else $error("low level interrupt missing");

  // high level value: low output stays quiet
  irq_lvlhigh_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_irq_code(2'h0) ##0 (ctrl_q[CES_ISLV_BIT] && !sense.level) |-> !irq_hit)
    else $error("interrupt on wrong level");

  // enabled interrupt event is latched and raised
  irq_sticky_a : assert property (@(posedge hclk) disable iff (!hresetn)
    irq_hit && ien_q[CES_ST_IRQ] |=> irq && stat_q[CES_ST_IRQ])
    else $error("interrupt event not latched");

  // irq follows status and enable while enable holds
  irq_follow_a : assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(ien_q) |-> irq == |(stat_q & ien_q))
    else $error("interrupt line disagrees with status");

  // a trigger event beats a same-cycle clear
  stat_setwin_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_clr_write ##0 trg_hit |=> stat_q[CES_ST_TRG])
    else $error("clear beat a trigger event");

  // a clear with no event empties the bit
  stat_clear_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_clr_write ##0 (hwdata[CES_ST_TRG] && !trg_hit) |=> !stat_q[CES_ST_TRG])
    else $error("trigger status not cleared");

  // one edge at a time from the detector
  edge_excl_a : assert property (@(posedge hclk) disable iff (!hresetn)
    !(sense.rise && sense.fall))
    else $error("rise and fall together");

  // read data comes out in the data phase
  rdata_phase_a : assert property (@(posedge hclk) disable iff (!hresetn)
    s_rd_addr |=> hrdata == $past(rdata_d))
    else $error("read data not loaded");

  // reserved control bits never set
  ctrl_mask_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl_q & ~CES_CTRL_MASK) == 32'h0000_0000)
    else $error("reserved control bit set");

endmodule : ces_top
